//--- verilog/bus_cycle_status_clock_qualifier.sv
`timescale 1ns/1ps
// Behaviour
// - memory/io read/write codes 000..011
// - refresh 100, first_fetch_status 101, ack 110, fetchN 111
// - store buffered normal/system bit
// - store interrupt request bit, 1 = requested
// - read/write bit, 1 read, 0 write
// - active-low shared-resource bit
// - capture data, address and segment buses
// - selectable master clock edge, 0 rising
// - AND six qualifiers with edge; default 1X11XX
// - default falling edge, qualify/halted/useful high
// - top qualifier is also driven by the wait line, default 1
// - second qualifier is wait line, default X
// - third qualifier active-low halted, default high
// - useful-cycle line low on idle/refresh/busack
// - read/write and shared qualifiers default X
// - user qualification kept when trigger removed
// - standard qualification restored at reset/reselect
// - segmented/non-segmented decode flag
// - halt recognised only at next first fetch
module bus_cycle_status_clock_qualifier (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // target processor pins (asynchronous)
  input  wire logic        tgt_clk_i,
  input  wire logic [15:0] tgt_data_i,
  input  wire logic [15:0] tgt_addr_i,
  input  wire logic [7:0]  tgt_seg_i,
  input  wire logic        tgt_rw_i,
  input  wire logic        tgt_io_i,
  input  wire logic        tgt_refresh_i,
  input  wire logic        tgt_fetch_i,
  input  wire logic        tgt_first_i,
  input  wire logic        tgt_ack_i,
  input  wire logic        tgt_internal_i,
  input  wire logic        tgt_busack_i,
  input  wire logic        tgt_normal_i,
  input  wire logic        tgt_irq_i,
  input  wire logic        shared_resource_flag_n_i,
  input  wire logic        tgt_wait_n_i,
  input  wire logic        tgt_halt_req_i,
  // analyzer side
  output logic             state_clk_o,
  output logic [15:0]      smp_data_o,
  output logic [15:0]      smp_addr_o,
  output logic [7:0]       smp_seg_o,
  output logic [2:0]       smp_status_o,
  output logic             smp_normal_o,
  output logic             smp_irq_o,
  output logic             smp_rw_o,
  output logic             smp_shared_n_o,
  output logic [5:0]       smp_qualify_line_o,
  output logic             nonsegmented_o,
  output logic             halted_n_o
);

  // fixed priority: refresh and acknowledge win over the read/write kinds
  function automatic logic [2:0] encode_cycle(input logic refresh, input logic ack,
                                              input logic fetch, input logic first,
                                              input logic io, input logic rw);
    if (refresh) begin
      encode_cycle = probe_pkg::ST_REFRESH;
    end else if (ack) begin
      encode_cycle = probe_pkg::ST_ACK;
    end else if (fetch) begin
      encode_cycle = first ? probe_pkg::ST_FIRST_FETCH
                           : probe_pkg::ST_LATER_FETCH;
    end else begin
      encode_cycle = {1'b0, io, rw};
    end
  endfunction

  // a care bit of 0 is don't care; otherwise the line must equal the value bit
  function automatic logic pattern_match(input logic [5:0] lines,
                                         input logic [5:0] val,
                                         input logic [5:0] care);
    logic [5:0] line_ok;
    line_ok       = ~care | ~(lines ^ val);
    pattern_match = &line_ok;
  endfunction

  // synchroniser: every pin sees the same two-stage latency, so a sample
  // taken on a detected edge is consistent across all fields
  logic [probe_pkg::PIN_W-1:0] pin_meta;
  logic [probe_pkg::PIN_W-1:0] pin_sync;
  logic                        clk_prev;
  // the three side pins have their own synchroniser with idle reset levels
  wire  [probe_pkg::PIN_W-1:0] pin_raw = {
    tgt_clk_i,
    tgt_data_i,
    tgt_addr_i,
    tgt_seg_i,
    tgt_rw_i,
    tgt_io_i,
    tgt_refresh_i,
    tgt_fetch_i,
    tgt_first_i,
    tgt_ack_i,
    tgt_internal_i,
    tgt_busack_i,
    tgt_normal_i,
    tgt_irq_i
  };

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[50];
    end
  end

  wire        s_clk      = pin_sync[50];
  wire [15:0] s_data     = pin_sync[49:34];
  wire [15:0] s_addr     = pin_sync[33:18];
  wire [7:0]  s_seg      = pin_sync[17:10];
  wire        s_rw       = pin_sync[9];
  wire        s_io       = pin_sync[8];
  wire        s_refresh  = pin_sync[7];
  wire        s_fetch    = pin_sync[6];
  wire        s_first    = pin_sync[5];
  wire        s_ack      = pin_sync[4];
  wire        s_internal = pin_sync[3];
  wire        s_busack   = pin_sync[2];
  wire        s_normal   = pin_sync[1];
  wire        s_irq      = pin_sync[0];

  // remaining synchronised pins
  logic [2:0] side_meta;
  logic [2:0] side_sync;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      side_meta <= probe_pkg::SIDE_IDLE;
      side_sync <= probe_pkg::SIDE_IDLE;
    end else begin
      side_meta <= {shared_resource_flag_n_i, tgt_wait_n_i, tgt_halt_req_i};
      side_sync <= side_meta;
    end
  end
  wire s_shared_n = side_sync[2];
  wire s_wait_n   = side_sync[1];
  wire s_halt_req = side_sync[0];

  // control state
  logic       edge_sel;
  logic       user_qualify_line;
  logic       nonseg;
  logic       trigger_on;
  logic [5:0] user_val;
  logic [5:0] user_care;
  logic       halt_pending;
  logic       halted;
  logic [31:0] sample_count;

  // effective qualification: standard settings unless user mode selected
  wire       eff_edge = user_qualify_line ? edge_sel : probe_pkg::STD_EDGE;
  wire [5:0] eff_val  = user_qualify_line ? user_val : probe_pkg::STD_QUALIFY_LINE_VAL;
  wire [5:0] eff_care = user_qualify_line ? user_care : probe_pkg::STD_QUALIFY_LINE_CARE;

  wire rise_seen = s_clk & ~clk_prev;
  wire fall_seen = ~s_clk & clk_prev;
  wire edge_hit  = eff_edge ? fall_seen : rise_seen;

  wire [2:0] cycle_code = encode_cycle(s_refresh, s_ack, s_fetch, s_first,
                                       s_io, s_rw);
  wire       is_first   = (cycle_code == probe_pkg::ST_FIRST_FETCH);

  // qualifier lines, highest first
  wire q_top    = s_wait_n;
  wire q_wait   = s_wait_n;
  wire q_halted = ~halted;
  wire q_useful = ~(s_internal | s_refresh | s_busack);
  wire q_rw     = s_rw;
  wire q_shared = s_shared_n;
  wire [5:0] qualify_line_lines = {q_top, q_wait, q_halted, q_useful, q_rw, q_shared};

  wire qualified = edge_hit & pattern_match(qualify_line_lines, eff_val, eff_care);

  // every field holds until the next qualified edge
  wire [15:0] next_data     = qualified ? s_data : smp_data_o;
  wire [15:0] next_addr     = qualified ? s_addr : smp_addr_o;
  wire [7:0]  next_seg      = qualified ? s_seg : smp_seg_o;
  wire [2:0]  next_status   = qualified ? cycle_code : smp_status_o;
  wire        next_normal   = qualified ? s_normal : smp_normal_o;
  wire        next_irq      = qualified ? s_irq : smp_irq_o;
  wire        next_rw       = qualified ? s_rw : smp_rw_o;
  wire        next_shared_n = qualified ? s_shared_n : smp_shared_n_o;
  wire [5:0]  next_qualify_line     = qualified ? qualify_line_lines : smp_qualify_line_o;
  wire [31:0] next_count    = qualified ? sample_count + 32'h0000_0001 : sample_count;

  // capture of one state sample
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_clk_o    <= 1'b0;
      smp_data_o     <= 16'h0000;
      smp_addr_o     <= 16'h0000;
      smp_seg_o      <= 8'h00;
      smp_status_o   <= 3'h0;
      smp_normal_o   <= 1'b0;
      smp_irq_o      <= 1'b0;
      smp_rw_o       <= 1'b0;
      smp_shared_n_o <= 1'b1;
      smp_qualify_line_o     <= 6'h00;
      sample_count   <= 32'h0000_0000;
    end else begin
      state_clk_o    <= qualified;
      smp_data_o     <= next_data;
      smp_addr_o     <= next_addr;
      smp_seg_o      <= next_seg;
      smp_status_o   <= next_status;
      smp_normal_o   <= next_normal;
      smp_irq_o      <= next_irq;
      smp_rw_o       <= next_rw;
      smp_shared_n_o <= next_shared_n;
      smp_qualify_line_o     <= next_qualify_line;
      sample_count   <= next_count;
    end
  end

  // bus slave: every access sees waitrequest high for one cycle, then low
  // for one; the write lands at the edge where waitrequest is seen low
  wire        req      = avs_read_i | avs_write_i;
  wire        wr_take  = avs_write_i & ~avs_waitrequest_o;
  wire        hit_ctrl = (avs_address_i == {4'h0, probe_pkg::OFF_CTRL});
  wire        hit_qualify_line = (avs_address_i == {4'h0, probe_pkg::OFF_QUALIFY_LINE});
  wire        ctrl_wr  = wr_take & hit_ctrl;
  wire        qualify_line_wr  = wr_take & hit_qualify_line;

  // write data fields
  wire        wd_edge    = avs_writedata_i[probe_pkg::CTRL_EDGE];
  wire        wd_user    = avs_writedata_i[probe_pkg::CTRL_USER];
  wire        wd_nonseg  = avs_writedata_i[probe_pkg::CTRL_NONSEG];
  wire        wd_trigger = avs_writedata_i[probe_pkg::CTRL_TRIGGER];
  wire        wd_halt    = avs_writedata_i[probe_pkg::CTRL_HALT_REQ];
  wire        wd_resume  = avs_writedata_i[probe_pkg::CTRL_RESUME];
  wire [5:0]  wd_val     = avs_writedata_i[probe_pkg::QUALIFY_LINE_VAL_LSB +: 6];
  wire [5:0]  wd_care    = avs_writedata_i[probe_pkg::QUALIFY_LINE_CARE_LSB +: 6];

  wire        sw_halt  = ctrl_wr & wd_halt;
  wire        resume   = ctrl_wr & wd_resume;
  wire        to_std   = ctrl_wr & ~wd_user;

  // read words, one per mapped register except the count, which is read from sample_count
  wire [31:0] rd_ctrl = {
    26'h0,
    1'b0,
    1'b0,
    trigger_on,
    nonseg,
    user_qualify_line,
    edge_sel
  };
  wire [31:0] rd_qualify_line = {
    18'h0,
    user_care,
    2'h0,
    user_val
  };
  wire [31:0] rd_status = {
    24'h0,
    qualify_line_lines,
    halt_pending,
    halted
  };
  wire [31:0] rd_busword = {smp_addr_o, smp_data_o};
  wire [31:0] rd_side = {
    16'h0,
    smp_seg_o,
    1'b0,
    smp_status_o,
    smp_normal_o,
    smp_irq_o,
    smp_rw_o,
    smp_shared_n_o
  };

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      {4'h0, probe_pkg::OFF_CTRL}:    rd_mux = rd_ctrl;
      {4'h0, probe_pkg::OFF_QUALIFY_LINE}:    rd_mux = rd_qualify_line;
      {4'h0, probe_pkg::OFF_STATUS}:  rd_mux = rd_status;
      {4'h0, probe_pkg::OFF_BUSWORD}: rd_mux = rd_busword;
      probe_pkg::OFF_SIDE:            rd_mux = rd_side;
      probe_pkg::OFF_COUNT:           rd_mux = sample_count;
      default:                        rd_mux = 32'h0000_0000;
    endcase
  end

  // the read word is latched when the access is taken and held until the next
  wire        take_req      = req & avs_waitrequest_o;
  wire        next_waitreq  = ~take_req;
  wire [31:0] next_readdata = take_req ? (avs_read_i ? rd_mux : 32'h0000_0000)
                                       : avs_readdata_o;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= next_waitreq;
      avs_readdata_o    <= next_readdata;
    end
  end

  // clock qualification settings; dropping the trigger leaves them untouched
  wire       next_user_qualify_line = ctrl_wr ? wd_user : user_qualify_line;
  wire       next_nonseg    = ctrl_wr ? wd_nonseg : nonseg;
  wire       next_trigger   = ctrl_wr ? wd_trigger : trigger_on;
  wire       next_edge_sel  = ~ctrl_wr ? edge_sel
                            : to_std   ? probe_pkg::STD_EDGE
                            : wd_edge;
  wire [5:0] next_user_val  = to_std  ? probe_pkg::STD_QUALIFY_LINE_VAL
                            : qualify_line_wr ? wd_val
                            : user_val;
  wire [5:0] next_user_care = to_std  ? probe_pkg::STD_QUALIFY_LINE_CARE
                            : qualify_line_wr ? wd_care
                            : user_care;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_sel   <= probe_pkg::STD_EDGE;
      user_qualify_line  <= 1'b0;
      user_val   <= probe_pkg::STD_QUALIFY_LINE_VAL;
      user_care  <= probe_pkg::STD_QUALIFY_LINE_CARE;
      nonseg     <= probe_pkg::RST_NONSEG;
      trigger_on <= probe_pkg::RST_TRIGGER;
    end else begin
      edge_sel   <= next_edge_sel;
      user_qualify_line  <= next_user_qualify_line;
      user_val   <= next_user_val;
      user_care  <= next_user_care;
      nonseg     <= next_nonseg;
      trigger_on <= next_trigger;
    end
  end

  // halt requests wait for a first fetch; a new request beats its own clearing
  wire halt_in           = s_halt_req | sw_halt;
  wire halt_take         = edge_hit & is_first & halt_pending;
  wire next_halt_pending = halt_in | (halt_pending & ~halt_take);
  wire next_halted       = halt_take | (halted & ~resume);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_pending   <= 1'b0;
      halted         <= 1'b0;
      halted_n_o     <= 1'b1;
      nonsegmented_o <= probe_pkg::RST_NONSEG;
    end else begin
      halt_pending   <= next_halt_pending;
      halted         <= next_halted;
      halted_n_o     <= ~next_halted;
      nonsegmented_o <= next_nonseg;
    end
  end

endmodule

//--- verilog/probe_pkg.sv
package probe_pkg;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_QUALIFY_LINE    = 4'h4;
  localparam logic [3:0] OFF_STATUS  = 4'h8;
  localparam logic [3:0] OFF_BUSWORD = 4'hC;
  localparam logic [7:0] OFF_SIDE    = 8'h10;
  localparam logic [7:0] OFF_COUNT   = 8'h14;

  // control register fields
  localparam int CTRL_EDGE     = 0;
  localparam int CTRL_USER     = 1;
  localparam int CTRL_NONSEG   = 2;
  localparam int CTRL_TRIGGER  = 3;
  localparam int CTRL_HALT_REQ = 4;
  localparam int CTRL_RESUME   = 5;

  // qualifier register fields
  localparam int QUALIFY_LINE_VAL_LSB  = 0;
  localparam int QUALIFY_LINE_CARE_LSB = 8;

  // cycle status codes
  localparam logic [2:0] ST_MEM_WRITE   = 3'h0;
  localparam logic [2:0] ST_MEM_READ    = 3'h1;
  localparam logic [2:0] ST_IO_WRITE    = 3'h2;
  localparam logic [2:0] ST_IO_READ     = 3'h3;
  localparam logic [2:0] ST_REFRESH     = 3'h4;
  localparam logic [2:0] ST_FIRST_FETCH = 3'h5;
  localparam logic [2:0] ST_ACK         = 3'h6;
  localparam logic [2:0] ST_LATER_FETCH = 3'h7;

  // standard qualification: falling edge, pattern 1X11XX (top..shared)
  localparam logic       STD_EDGE      = 1'b1;
  localparam logic [5:0] STD_QUALIFY_LINE_VAL  = 6'h2C;
  localparam logic [5:0] STD_QUALIFY_LINE_CARE = 6'h2C;
  localparam logic       RST_NONSEG    = 1'b0;
  localparam logic       RST_TRIGGER   = 1'b1;
  // idle levels of {shared_n, wait_n, halt request}: a request that reads
  // high out of reset would halt the target at its first fetch
  localparam logic [2:0] SIDE_IDLE     = 3'h6;

  // number of pins passed through the synchroniser
  localparam int PIN_W = 51;
endpackage

//--- testbench/bcq_chk.sv
`timescale 1ns/1ps
module bcq_chk (
  // clock, reset, register bus
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // sample side
  input wire logic        state_clk_o,
  input wire logic [2:0]  smp_status_o,
  input wire logic        smp_rw_o,
  input wire logic        smp_shared_n_o,
  input wire logic [5:0]  smp_qualify_line_o,
  input wire logic        nonsegmented_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered next cycle");
  answer_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h14
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  nonseg_flag_a: assert property (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
    && avs_writedata_i[2] |-> ##[1:2] nonsegmented_o) else $error("mode flag not set");
  sample_hold_a: assert property (!state_clk_o |-> $stable(smp_status_o) && $stable(smp_rw_o))
    else $error("sample changed without state clock");
  one_sample_a: assert property (state_clk_o |=> !state_clk_o [*8])
    else $error("state clock pulses too close");
  code_rw_a: assert property (state_clk_o && !smp_status_o[2] |-> smp_status_o[0] == smp_rw_o)
    else $error("status code disagrees with direction");
  refresh_useless_a: assert property (state_clk_o && smp_status_o == probe_pkg::ST_REFRESH
    |-> !smp_qualify_line_o[2]) else $error("useful line high on refresh");
  side_qualify_line_a: assert property (state_clk_o |-> smp_qualify_line_o[1] == smp_rw_o
    && smp_qualify_line_o[0] == smp_shared_n_o) else $error("qualifier lines wrong");
endmodule
bind bus_cycle_status_clock_qualifier bcq_chk u_bcq_chk (.core_clk_i, .rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .state_clk_o, .smp_status_o, .smp_rw_o, .smp_shared_n_o, .smp_qualify_line_o, .nonsegmented_o);

//--- testbench/tgt_bus_model.sv
`timescale 1ns/1ps
module tgt_bus_model (
  // next cycle and sampling edge (1 falling)
  input  wire logic [52:0] cyc_i,
  input  wire logic        edge_i,
  // master clock and pins
  output logic             tgt_clk_o,
  output logic [52:0]      pins_o
);
  // the master clock runs free; pins move on the edge opposite the sampling one
  initial begin
    tgt_clk_o = 1'b0;
    pins_o = 53'h6;
    forever #80 tgt_clk_o = ~tgt_clk_o;
  end
  always @(tgt_clk_o) begin
    if (tgt_clk_o == edge_i) begin
      pins_o <= cyc_i;
    end
  end
endmodule

//--- testbench/bus_cycle_status_clock_qualifier_tb.sv
`timescale 1ns/1ps
module bus_cycle_status_clock_qualifier_tb;
  logic core_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] avs_address_i, smp_seg_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, seed;
  logic state_clk_o, smp_normal_o, smp_irq_o, smp_rw_o, smp_shared_n_o;
  logic [15:0] smp_data_o, smp_addr_o;
  logic [2:0] smp_status_o;
  logic [5:0] smp_qualify_line_o;
  logic nonsegmented_o, halted_n_o, tgt_clk, edge_s;
  logic [52:0] pins, cyc_v;
  int mismatches, samples_checked;
  tgt_bus_model u_tgt_bus_model (.cyc_i(cyc_v), .edge_i(edge_s), .tgt_clk_o(tgt_clk),
    .pins_o(pins));
  bus_cycle_status_clock_qualifier u_bus_cycle_status_clock_qualifier (.core_clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .tgt_clk_i(tgt_clk), .tgt_data_i(pins[52:37]),
    .tgt_addr_i(pins[36:21]), .tgt_seg_i(pins[20:13]), .tgt_rw_i(pins[12]),
    .tgt_io_i(pins[11]), .tgt_refresh_i(pins[10]), .tgt_fetch_i(pins[9]),
    .tgt_first_i(pins[8]), .tgt_ack_i(pins[7]), .tgt_internal_i(pins[6]),
    .tgt_busack_i(pins[5]), .tgt_normal_i(pins[4]), .tgt_irq_i(pins[3]),
    .shared_resource_flag_n_i(pins[2]), .tgt_wait_n_i(pins[1]), .tgt_halt_req_i(pins[0]),
    .state_clk_o, .smp_data_o, .smp_addr_o, .smp_seg_o, .smp_status_o, .smp_normal_o,
    .smp_irq_o, .smp_rw_o, .smp_shared_n_o, .smp_qualify_line_o, .nonsegmented_o, .halted_n_o);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      chk("bus answer", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // pins of one bus cycle whose status code should come out as k
  function automatic logic [52:0] mk(input logic [2:0] k, input logic [31:0] r);
    mk = {r, r[15:8] ^ r[7:0], 13'h6};
    mk[12] = (k < 3'h4) ? k[0] : 1'b1;
    mk[11] = (k < 3'h4) & k[1];
    mk[10] = (k == 3'h4);
    mk[9] = k[2] & k[0];
    mk[8] = (k == 3'h5);
    mk[7] = (k == 3'h6);
    mk[4:2] = r[18:16];
  endfunction
  // m: 0 standard, 1 all don't care, 2 read only, 3 never sampled
  task automatic cyc(input logic [2:0] k, input logic [1:0] m, input logic h);
    logic [52:0] v;
    logic hit;
    logic exp_hit;
    seed = lfsr(seed);
    v = mk(k, seed);
    v[0] = h;
    if (m == 2'd0) begin
      v[6] = seed[5] & seed[6];
      v[5] = seed[9] & seed[10];
      v[1] = !(seed[11] & seed[12]);
    end
    case (m)
      2'd0: exp_hit = v[1] & !v[6] & !v[5] & !v[10];
      2'd1: exp_hit = 1'b1;
      2'd2: exp_hit = v[12];
      default: exp_hit = 1'b0;
    endcase
    @(posedge core_clk_i);
    cyc_v <= v;
    @(tgt_clk iff tgt_clk == edge_s);
    @(tgt_clk);
    hit = 1'b0;
    for (int n = 0; n < 12 && !hit; n++) begin
      @(posedge core_clk_i);
      #1;
      hit = (state_clk_o === 1'b1);
    end
    chk("sample taken", 32'(exp_hit), 32'(hit));
    if (hit && exp_hit) begin
      chk("status", 32'(k), 32'(smp_status_o));
      chk("data addr", v[52:21], {smp_data_o, smp_addr_o});
      chk("segment", 32'(v[20:13]), 32'(smp_seg_o));
      chk("flags", 32'({v[12], v[4:2]}),
          32'({smp_rw_o, smp_normal_o, smp_irq_o, smp_shared_n_o}));
      chk("qualifiers", 32'({v[1], v[1], 1'b1, !(v[6] | v[10] | v[5]), v[12], v[2]}),
          32'(smp_qualify_line_o));
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // hang guard
  initial begin
    #200000;
    chk("run time", 32'h1, 32'h0);
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    seed = 32'h272F;
    cyc_v = 53'h6;
    edge_s = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk("reset", 32'h5, {29'h0, avs_waitrequest_o, nonsegmented_o, halted_n_o});
    rd("qualify_line reset", 8'h04, 32'h00002C2C);
    $display("test reset done");
    for (int k = 0; k < 8; k++) cyc(3'(k), 2'd0, 1'b0);
    repeat (40) cyc(seed[2:0], 2'd0, 1'b0);
    $display("test standard done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hB);
    for (int k = 0; k < 8; k++) cyc(3'(k), 2'd1, 1'b0);
    wr(8'h04, 32'h0202);
    wr(8'h00, 32'hA);
    edge_s <= 1'b0;
    for (int k = 0; k < 8; k++) cyc(3'(k), 2'd2, 1'b0);
    $display("test user qualification done");
    wr(8'h00, 32'h2);
    rd("qualify_line kept", 8'h04, 32'h00000202);
    wr(8'h00, 32'h8);
    edge_s <= 1'b1;
    rd("qualify_line restored", 8'h04, 32'h00002C2C);
    wr(8'h00, 32'hC);
    repeat (3) @(posedge core_clk_i);
    chk("nonsegmented", 32'h1, 32'(nonsegmented_o));
    wr(8'h00, 32'h8);
    repeat (3) @(posedge core_clk_i);
    chk("segmented", 32'h0, 32'(nonsegmented_o));
    rd("unmapped", 8'h40, 32'h0);
    $display("test registers done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hB);
    cyc(3'h1, 2'd1, 1'b1);
    repeat (4) @(posedge core_clk_i);
    chk("halt before fetch", 32'h1, 32'(halted_n_o));
    cyc(3'h5, 2'd1, 1'b1);
    repeat (4) @(posedge core_clk_i);
    chk("halt at fetch", 32'h0, 32'(halted_n_o));
    wr(8'h00, 32'h8);
    cyc(3'h1, 2'd3, 1'b0);
    wr(8'h00, 32'h28);
    repeat (3) @(posedge core_clk_i);
    chk("resumed", 32'h1, 32'(halted_n_o));
    $display("test halt done");
    report_and_stop();
  end
endmodule
